// File: core/llsd_pkg.sv
// Purpose: constants and types shared by the linked-list sort dma engine
// Assumes: AHB-Lite word registers at the printed byte addresses
// Notes: status offset and error check are local choices
// What this block does
// - writing one to start control launches the list walk
// - start link entries are fetched in order from the table pointer
// - fetch address is link base plus decoded link offset
// - width select picks 16-bit or 32-bit table entries
// - shift select multiplies link values by 32 when set
// - start entry one means end of list, read next entry
// - start entry two means end of dma, finish
// - size comes from byte 0x18, next link from byte 0x1c
// - size counts 32-byte units, 4 to 255, zero means 8192 bytes
// - next link one returns to the start link table
// - next link two ends the whole transfer
// - 32 or 64 byte global blocks share the link word offsets
// - no texture memory destination register exists here
// - normal end clears start control and sets end flag bit 20
// - writing zero requests stop; start reads one until halted, no flag
// - missing global parameters abort and set error flag bit 28
// - entries read are counted in the start link read count register
`default_nettype none
package llsd_pkg;
	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [31:0] LINK_TABLE_POINTER_ADDR = 32'h005F6810;
	localparam logic [31:0] LINK_BASE_ADDRESS_ADDR = 32'h005F6814;
	localparam logic [31:0] LINK_WIDTH_SELECT_ADDR = 32'h005F6818;
	localparam logic [31:0] LINK_SHIFT_SELECT_ADDR = 32'h005F681C;
	localparam logic [31:0] SORT_START_CONTROL_ADDR = 32'h005F6820;
	localparam logic [31:0] START_LINK_READ_COUNT_ADDR = 32'h005F6860;
	localparam logic [31:0] NORMAL_INTERRUPT_STATUS_ADDR = 32'h005F6830;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam int END_FLAG_BIT = 20;
	localparam int PERR_FLAG_BIT = 28;
	// -----------------------------------------------------------------
	// link codes and polygon layout
	// -----------------------------------------------------------------
	localparam logic [31:0] LINK_END_OF_LIST = 32'h00000001;
	localparam logic [31:0] LINK_END_OF_DMA = 32'h00000002;
	localparam int LINK_UNIT_SHIFT = 5;
	localparam logic [10:0] SIZE_WORD_IDX = 11'h006;
	localparam logic [10:0] NEXT_WORD_IDX = 11'h007;
	localparam logic [7:0] SIZE_MIN = 8'h04;
	localparam logic [11:0] SIZE_ZERO_WORDS = 12'h800;
	localparam int CLK_PERIOD_NS = 40;
	// -----------------------------------------------------------------
	// engine states
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_TAB_RD = 4'b0010,
		ST_POLY_RD = 4'b0100,
		ST_POLY_OUT = 4'b1000
	} llsd_state_type;
endpackage
`default_nettype wire

// File: core/llsd_link_decode.sv
// Purpose: decode one link value into end codes and a byte offset
// Assumes: little-endian halves inside a fetched word
// Notes: purely combinational
`default_nettype none
module llsd_link_decode
(
	input wire logic [31:0] word_i,
	input wire logic half_i,
	input wire logic wide_i,
	input wire logic shift_i,
	output logic eol_o,
	output logic eod_o,
	output logic [31:0] offset_o
);
	logic [31:0] raw;
	// narrow entries take one half, zero extended
	always_comb
	begin
		raw = wide_i ? word_i : {16'h0000, half_i ? word_i[31:16] : word_i[15:0]};
		eol_o = (raw == llsd_pkg::LINK_END_OF_LIST);
		eod_o = (raw == llsd_pkg::LINK_END_OF_DMA);
		offset_o = shift_i ? (raw << llsd_pkg::LINK_UNIT_SHIFT) : raw;
	end
endmodule // llsd_link_decode
`default_nettype wire

// File: core/llsd_engine.sv
// Purpose: linked-list sort dma engine with AHB-Lite register slave
// Assumes: memory read port answers with a one-cycle ack; one clock
// Notes: destination in texture memory is set by the accelerator
`default_nettype none
module llsd_engine
(
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic mem_req_o,
	output logic [31:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	output logic ta_valid_o,
	output logic [31:0] ta_data_o,
	input wire logic ta_ready_i
);
	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		llsd_pkg::llsd_state_type st;
		logic [31:0] tab_ptr;
		logic [31:0] base;
		logic wsel;
		logic ssel;
		logic start;
		logic stop_req;
		logic end_flag;
		logic perr_flag;
		logic [31:0] count;
		logic [31:0] addr;
		logic [10:0] idx;
		logic [11:0] total;
		logic [31:0] next;
		logic [31:0] data;
		logic wr_pend;
		logic [31:0] wr_addr;
		logic [31:0] rdata;
	} llsd_regs_type;

	llsd_regs_type cur_r;
	llsd_regs_type cur_nxt;
	logic tab_eol, tab_eod, nl_eol, nl_eod;
	logic [31:0] tab_off, nl_off;
	logic ahb_go;

	// register address compare, used for reads and writes
	function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
		hit = (a[31:2] == r[31:2]);
	endfunction

	// -----------------------------------------------------------------
	// link decoders: table entry and next link word
	// -----------------------------------------------------------------
	llsd_link_decode u_tab_dec
	(
		.word_i(mem_rdata_i),
		.half_i(cur_r.addr[1]),
		.wide_i(cur_r.wsel),
		.shift_i(cur_r.ssel),
		.eol_o(tab_eol),
		.eod_o(tab_eod),
		.offset_o(tab_off)
	);
	llsd_link_decode u_nl_dec
	(
		.word_i(cur_r.next),
		.half_i(1'b0),
		.wide_i(1'b1),
		.shift_i(cur_r.ssel),
		.eol_o(nl_eol),
		.eod_o(nl_eod),
		.offset_o(nl_off)
	);

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	assign ahb_go = hsel_i && htrans_i[1] && hready_i;
	always_comb
	begin
		cur_nxt = cur_r;
		// bus write data phase; pointer, base and select registers take writes while busy too
		cur_nxt.wr_pend = ahb_go && hwrite_i;
		if (ahb_go && hwrite_i)
		begin
			cur_nxt.wr_addr = haddr_i;
		end
		if (cur_r.wr_pend)
		begin
			if (hit(cur_r.wr_addr, llsd_pkg::LINK_TABLE_POINTER_ADDR))
			begin
				cur_nxt.tab_ptr = hwdata_i;
			end
			if (hit(cur_r.wr_addr, llsd_pkg::LINK_BASE_ADDRESS_ADDR))
			begin
				cur_nxt.base = hwdata_i;
			end
			if (hit(cur_r.wr_addr, llsd_pkg::LINK_WIDTH_SELECT_ADDR))
			begin
				cur_nxt.wsel = hwdata_i[0];
			end
			if (hit(cur_r.wr_addr, llsd_pkg::LINK_SHIFT_SELECT_ADDR))
			begin
				cur_nxt.ssel = hwdata_i[0];
			end
			// write-one clears; hardware sets below win
			if (hit(cur_r.wr_addr, llsd_pkg::NORMAL_INTERRUPT_STATUS_ADDR))
			begin
				cur_nxt.end_flag = cur_r.end_flag & ~hwdata_i[llsd_pkg::END_FLAG_BIT];
				cur_nxt.perr_flag = cur_r.perr_flag & ~hwdata_i[llsd_pkg::PERR_FLAG_BIT];
			end
			if (hit(cur_r.wr_addr, llsd_pkg::SORT_START_CONTROL_ADDR))
			begin
				if (hwdata_i[0] && cur_r.st == llsd_pkg::ST_IDLE)
				begin
					cur_nxt.start = 1'b1;
					cur_nxt.stop_req = 1'b0;
					cur_nxt.count = 32'h00000000;
					cur_nxt.addr = {cur_r.tab_ptr[31:2], 2'b00} | {30'h0, cur_r.tab_ptr[1], 1'b0};
					cur_nxt.st = llsd_pkg::ST_TAB_RD;
				end
				else if (!hwdata_i[0] && cur_r.start)
				begin
					cur_nxt.stop_req = 1'b1;
				end
			end
		end
		// engine
		unique case (cur_r.st)
			llsd_pkg::ST_IDLE:
			begin
			end
			llsd_pkg::ST_TAB_RD:
			begin
				if (mem_ack_i)
				begin
					cur_nxt.count = cur_r.count + 32'h00000001;
					cur_nxt.tab_ptr = cur_r.tab_ptr + (cur_r.wsel ? 32'h4 : 32'h2);
					if (cur_r.stop_req)
					begin
						cur_nxt.start = 1'b0;
						cur_nxt.st = llsd_pkg::ST_IDLE;
					end
					else if (tab_eod)
					begin
						cur_nxt.start = 1'b0;
						cur_nxt.end_flag = 1'b1;
						cur_nxt.st = llsd_pkg::ST_IDLE;
					end
					else if (tab_eol)
					begin
						cur_nxt.addr = cur_r.tab_ptr + (cur_r.wsel ? 32'h4 : 32'h2);
					end
					else
					begin
						cur_nxt.addr = cur_r.base + tab_off;
						cur_nxt.idx = 11'h000;
						cur_nxt.total = llsd_pkg::SIZE_ZERO_WORDS; // upper bound until size seen
						cur_nxt.st = llsd_pkg::ST_POLY_RD;
					end
				end
			end
			llsd_pkg::ST_POLY_RD:
			begin
				if (mem_ack_i)
				begin
					cur_nxt.data = mem_rdata_i;
					cur_nxt.st = llsd_pkg::ST_POLY_OUT;
					// same word offsets for both global block sizes
					if (cur_r.idx == llsd_pkg::SIZE_WORD_IDX)
					begin
						cur_nxt.total = (mem_rdata_i[7:0] == 8'h00) ?
							llsd_pkg::SIZE_ZERO_WORDS : {1'b0, mem_rdata_i[7:0], 3'b000};
						// a size below the minimum means no global block here
						if (mem_rdata_i[7:0] != 8'h00 && mem_rdata_i[7:0] < llsd_pkg::SIZE_MIN)
						begin
							cur_nxt.perr_flag = 1'b1;
							cur_nxt.start = 1'b0;
							cur_nxt.st = llsd_pkg::ST_IDLE;
						end
					end
					if (cur_r.idx == llsd_pkg::NEXT_WORD_IDX)
					begin
						cur_nxt.next = mem_rdata_i;
					end
				end
			end
			llsd_pkg::ST_POLY_OUT:
			begin
				if (ta_ready_i)
				begin
					cur_nxt.idx = cur_r.idx + 11'h001;
					cur_nxt.addr = cur_r.addr + 32'h4;
					cur_nxt.st = llsd_pkg::ST_POLY_RD;
					if (cur_r.stop_req)
					begin
						cur_nxt.start = 1'b0;
						cur_nxt.st = llsd_pkg::ST_IDLE;
					end
					else if ({1'b0, cur_r.idx} + 12'h001 == cur_r.total)
					begin
						if (nl_eod)
						begin
							cur_nxt.start = 1'b0;
							cur_nxt.end_flag = 1'b1;
							cur_nxt.st = llsd_pkg::ST_IDLE;
						end
						else if (nl_eol)
						begin
							cur_nxt.addr = cur_r.tab_ptr;
							cur_nxt.st = llsd_pkg::ST_TAB_RD;
						end
						else
						begin
							cur_nxt.addr = cur_r.base + nl_off;
							cur_nxt.idx = 11'h000;
							cur_nxt.total = llsd_pkg::SIZE_ZERO_WORDS; // upper bound until size seen
						end
					end
				end
			end
		endcase
		// register read data, answered in the next data phase
		if (ahb_go && !hwrite_i)
		begin
			cur_nxt.rdata = 32'h00000000;
			if (hit(haddr_i, llsd_pkg::LINK_TABLE_POINTER_ADDR))
			begin
				cur_nxt.rdata = cur_r.tab_ptr;
			end
			if (hit(haddr_i, llsd_pkg::LINK_BASE_ADDRESS_ADDR))
			begin
				cur_nxt.rdata = cur_r.base;
			end
			if (hit(haddr_i, llsd_pkg::LINK_WIDTH_SELECT_ADDR))
			begin
				cur_nxt.rdata = {31'h0, cur_r.wsel};
			end
			if (hit(haddr_i, llsd_pkg::LINK_SHIFT_SELECT_ADDR))
			begin
				cur_nxt.rdata = {31'h0, cur_r.ssel};
			end
			if (hit(haddr_i, llsd_pkg::SORT_START_CONTROL_ADDR))
			begin
				cur_nxt.rdata = {31'h0, cur_r.start};
			end
			if (hit(haddr_i, llsd_pkg::START_LINK_READ_COUNT_ADDR))
			begin
				cur_nxt.rdata = cur_r.count;
			end
			if (hit(haddr_i, llsd_pkg::NORMAL_INTERRUPT_STATUS_ADDR))
			begin
				cur_nxt.rdata[llsd_pkg::END_FLAG_BIT] = cur_r.end_flag;
				cur_nxt.rdata[llsd_pkg::PERR_FLAG_BIT] = cur_r.perr_flag;
			end
		end
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			cur_r <= '0;
			cur_r.st <= llsd_pkg::ST_IDLE;
		end
		else
		begin
			cur_r <= cur_nxt;
		end
	end

	// outputs; zero wait states, always okay
	assign hrdata_o = cur_r.rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign mem_req_o = (cur_r.st == llsd_pkg::ST_TAB_RD) || (cur_r.st == llsd_pkg::ST_POLY_RD);
	assign mem_addr_o = cur_r.addr;
	assign ta_valid_o = (cur_r.st == llsd_pkg::ST_POLY_OUT);
	assign ta_data_o = cur_r.data;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_tab_eod;
		cur_r.st == llsd_pkg::ST_TAB_RD && mem_ack_i && tab_eod && !cur_r.stop_req;
	endsequence
	sequence s_stopped;
		cur_r.st == llsd_pkg::ST_IDLE && !cur_r.start && cur_r.end_flag;
	endsequence
	a_launch_fetch: assert property (cur_r.wr_pend && cur_r.st == llsd_pkg::ST_IDLE
		&& hit(cur_r.wr_addr, llsd_pkg::SORT_START_CONTROL_ADDR) && hwdata_i[0]
		|=> mem_req_o && cur_r.start)
		else $error("start write did not launch");
	a_table_step: assert property (cur_r.st == llsd_pkg::ST_TAB_RD && mem_ack_i
		|=> cur_r.tab_ptr == $past(cur_r.tab_ptr) + ($past(cur_r.wsel) ? 32'h4 : 32'h2))
		else $error("table pointer step wrong");
	a_dest_addr: assert property (cur_r.st == llsd_pkg::ST_TAB_RD && mem_ack_i
		&& !tab_eol && !tab_eod && !cur_r.stop_req |=> mem_addr_o == $past(cur_r.base + tab_off))
		else $error("link destination wrong");
	a_shift_mul: assert property (cur_r.st == llsd_pkg::ST_TAB_RD && mem_ack_i
		&& cur_r.ssel && cur_r.wsel && !tab_eol && !tab_eod
		|-> tab_off == {mem_rdata_i[26:0], 5'h00})
		else $error("shifted link not scaled by 32");
	a_eol_skip: assert property (cur_r.st == llsd_pkg::ST_TAB_RD && mem_ack_i && tab_eol
		&& !cur_r.stop_req |=> cur_r.st == llsd_pkg::ST_TAB_RD && !ta_valid_o)
		else $error("end of list not skipped");
	a_eod_done: assert property (s_tab_eod |=> s_stopped)
		else $error("end of dma did not finish");
	a_count_up: assert property (cur_r.st == llsd_pkg::ST_TAB_RD && mem_ack_i
		|=> cur_r.count == $past(cur_r.count) + 32'h1)
		else $error("read count not advanced");
	a_stop_noflag: assert property (cur_r.stop_req && $fell(cur_r.start)
		|-> $stable(cur_r.end_flag) && $stable(cur_r.perr_flag))
		else $error("stopped transfer raised a flag");
	a_size_bad: assert property (cur_r.st == llsd_pkg::ST_POLY_RD && mem_ack_i
		&& cur_r.idx == llsd_pkg::SIZE_WORD_IDX && mem_rdata_i[7:0] != 8'h00
		&& mem_rdata_i[7:0] < llsd_pkg::SIZE_MIN |=> cur_r.perr_flag && !cur_r.start)
		else $error("bad size did not abort");
	a_data_hold: assert property (ta_valid_o && !ta_ready_i
		|=> ta_valid_o && $stable(ta_data_o))
		else $error("stream word dropped");
endmodule // llsd_engine
`default_nettype wire

// File: bench/llsd_far_model.sv
// Purpose: far side of the sort dma engine: system memory and accelerator input
// Assumes: sparse word memory loaded by the bench at aligned byte addresses
// Notes: slow_i adds random read latency and accelerator stalls
`default_nettype none
module llsd_far_model
(
	input wire logic sys_clk_i,
	input wire logic slow_i,
	input wire logic mem_req_i,
	input wire logic [31:0] mem_addr_i,
	output logic mem_ack_o,
	output logic [31:0] mem_rdata_o,
	input wire logic ta_valid_i,
	input wire logic [31:0] ta_data_i,
	output logic ta_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [logic [31:0]];
	logic [31:0] got [$];
	// -----------------------------------------------------------------
	// memory read port and accelerator sink
	// -----------------------------------------------------------------
	// quiet state before the first clock edge
	initial
	begin
		mem_ack_o = 1'b0;
		mem_rdata_o = 32'h5A5A5A5A;
		ta_ready_o = 1'b0;
	end
	// data toggles while no word is due, so a stale word never looks valid
	// the bench loads only aligned in-range links and whole blocks
	always @(posedge sys_clk_i)
	begin
		mem_ack_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		ta_ready_o <= !slow_i || $urandom_range(1, 0) == 1;
		if (ta_valid_i && ta_ready_o)
			got.push_back(ta_data_i);
		if (mem_req_i && !mem_ack_o && (!slow_i || $urandom_range(1, 0) == 1))
		begin
			mem_ack_o <= 1'b1;
			// upper-half narrow table entries ask with address bit 1 set; the word is aligned
			mem_rdata_o <= mem.exists({mem_addr_i[31:2], 2'b00}) ?
				mem[{mem_addr_i[31:2], 2'b00}] : 32'h00000000;
		end
	end
endmodule // llsd_far_model
`default_nettype wire

// File: bench/llsd_engine_tb.sv
// Purpose: self-checking bench for the linked-list sort dma engine
// Assumes: zero-wait register slave; far model serves memory and accelerator
// Notes: list shapes and block data are random from a fixed seed
`default_nettype none
module llsd_engine_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] T = 32'h0C600000;
	localparam logic [31:0] B = 32'h0C604000;
	localparam logic [31:0] TP = llsd_pkg::LINK_TABLE_POINTER_ADDR;
	localparam logic [31:0] ST = llsd_pkg::SORT_START_CONTROL_ADDR;
	localparam logic [31:0] RC = llsd_pkg::START_LINK_READ_COUNT_ADDR;
	localparam logic [31:0] IS = llsd_pkg::NORMAL_INTERRUPT_STATUS_ADDR;
	logic clk, rst_n, hsel, hwrite, slow, mreq, mack, tv, tr, hro, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, maddr, mrd, tdat, rd;
	logic [31:0] q [$];
	logic [31:0] ra [8] = '{TP, llsd_pkg::LINK_BASE_ADDRESS_ADDR,
		llsd_pkg::LINK_WIDTH_SELECT_ADDR, llsd_pkg::LINK_SHIFT_SELECT_ADDR, ST, RC, IS,
		32'h005F6900};
	int mismatches, checks, cyc;

	llsd_engine dut (.sys_clk_i(clk), .reset_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hro), .hrdata_o(hrdata), .hreadyout_o(hro), .hresp_o(hresp),
		.mem_req_o(mreq), .mem_addr_o(maddr), .mem_ack_i(mack), .mem_rdata_i(mrd),
		.ta_valid_o(tv), .ta_data_o(tdat), .ta_ready_i(tr));
	llsd_far_model u_far (.sys_clk_i(clk), .slow_i(slow), .mem_req_i(mreq),
		.mem_addr_i(maddr), .mem_ack_o(mack), .mem_rdata_o(mrd), .ta_valid_i(tv),
		.ta_data_i(tdat), .ta_ready_o(tr));
	// -----------------------------------------------------------------
	// clock, hang guard and helpers
	// -----------------------------------------------------------------
	// 40 ns period
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ceiling well above the longest run, a 2048-word block included
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one single transfer; starts just after an edge, ends at the data-phase edge
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hro !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hro !== 1'b1);
		rd = hrdata;
	endtask
	function automatic logic [31:0] lv(input logic [31:0] o, input logic sh);
		return sh ? o >> 5 : o;
	endfunction
	// block of sz 32-byte units, size and link in words 6 and 7
	task automatic put_poly(input logic [31:0] off, nxt, input logic [7:0] sz);
		logic [31:0] w;
		for (int i = 0; i < (sz == 8'h00 ? 2048 : 8 * sz); i++)
		begin
			w = (i == 6) ? {24'h0, sz} : (i == 7) ? nxt : $urandom;
			u_far.mem[B + off + 4 * i] = w;
			q.push_back(w);
		end
	endtask
	// software must see the engine idle before launching
	task automatic go(input logic wide, sh);
		bus(1'b1, TP, T);
		bus(1'b1, ra[1], B);
		bus(1'b1, ra[2], {31'h0, wide});
		bus(1'b1, ra[3], {31'h0, sh});
		bus(1'b0, ST, 32'h0);
		check("idle start", rd, 32'h0);
		bus(1'b1, ST, 32'h1);
	endtask
	task automatic wait_idle();
		do bus(1'b0, ST, 32'h0); while (rd !== 32'h0);
	endtask
	task automatic cmp_stream();
		check("words", 32'(u_far.got.size()), 32'(q.size()));
		foreach (q[k])
			check("word", u_far.got[k], q[k]);
	endtask
	// three blocks: table, skip code, chained link, end code
	task automatic run(input logic wide, sh);
		logic [31:0] o [3];
		logic [31:0] e [4];
		u_far.mem.delete();
		u_far.got.delete();
		q.delete();
		slow <= 1'($urandom_range(1, 0));
		// offsets start at 0x80 so a shifted link never looks like an end code
		foreach (o[k])
			o[k] = 32'h2000 * k + 32'h80 + ({$urandom_range(15, 0)} << 5);
		e = '{lv(o[0], sh), 32'h1, lv(o[1], sh), 32'h2};
		put_poly(o[0], lv(o[2], sh), 8'($urandom_range(6, 4)));
		put_poly(o[2], 32'h1, 8'($urandom_range(6, 4)));
		put_poly(o[1], wide ? 32'h2 : 32'h1, 8'h04);
		// narrow entries pack two to a word, low half first
		for (int i = 0; i < (wide ? 4 : 2); i++)
			u_far.mem[T + 4 * i] = wide ? e[i] : {e[2 * i + 1][15:0], e[2 * i][15:0]};
		go(wide, sh);
		wait_idle();
		cmp_stream();
		bus(1'b0, RC, 32'h0);
		check("count", rd, wide ? 32'h3 : 32'h4);
		bus(1'b0, TP, 32'h0);
		check("table ptr", rd, T + (wide ? 32'hC : 32'h8));
		bus(1'b0, IS, 32'h0);
		check("end flag", rd, 32'h00100000);
		bus(1'b1, IS, 32'h00100000);
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		slow = 1'b0;
		void'($urandom(71));
		repeat (20) @(posedge clk);
		rst_n <= 1'b0 + 1'b1;
		@(posedge clk);
		foreach (ra[k])
		begin
			bus(1'b0, ra[k], 32'h0);
			check("reset value", rd, 32'h0);
		end
		bus(1'b1, RC, $urandom);
		bus(1'b0, RC, 32'h0);
		check("read-only count", rd, 32'h0);
		for (int m = 0; m < 4; m++)
			run(m[0], m[1]);
		// size zero is a full 8192-byte block; then the same list is stopped early
		u_far.mem.delete();
		u_far.got.delete();
		q.delete();
		slow <= 1'b0;
		put_poly(32'h0, 32'h2, 8'h00);
		u_far.mem[T] = 32'h0;
		go(1'b1, 1'b0);
		wait_idle();
		cmp_stream();
		bus(1'b1, IS, 32'h00100000);
		slow <= 1'b1;
		go(1'b1, 1'b0);
		bus(1'b1, ST, 32'h0);
		bus(1'b0, ST, 32'h0);
		check("stopping", rd, 32'h1);
		wait_idle();
		bus(1'b0, IS, 32'h0);
		check("no end flag", rd, 32'h0);
		// a size below four means no global block was found
		u_far.mem.delete();
		put_poly(32'h0, 32'h2, 8'h03);
		u_far.mem[T] = 32'h0;
		go(1'b1, 1'b0);
		wait_idle();
		bus(1'b0, IS, 32'h0);
		check("param error", rd, 32'h10000000);
		print_verdict();
	end
endmodule // llsd_engine_tb
`default_nettype wire
